// >>> logic/scsi_status_defines.svh
// constants for the target status and exception logic
`ifndef SCSI_STATUS_DEFINES_SVH
`define SCSI_STATUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// status byte codes, reserved bits already zero
// ----------------------------------------------------------------------------
`define ST_GOOD          8'h00
`define ST_CHECK         8'h02
`define ST_COND_MET      8'h04
`define ST_BUSY          8'h08
`define ST_INTERMEDIATE  8'h10
`define ST_RESV_CONFLICT 8'h18
`define ST_QUEUE_FULL    8'h28
`define ST_RSVD_MASK     8'hC1

// ----------------------------------------------------------------------------
// sense keys and additional sense codes
// ----------------------------------------------------------------------------
`define SK_NO_SENSE      4'h0
`define SK_ILLEGAL_REQ   4'h5
`define SK_EQUAL         4'hC
`define ASC_NONE         8'h00
`define ASC_INVALID_FLD  8'h24
`define ASC_INVALID_LUN  8'h25

// ----------------------------------------------------------------------------
// inquiry peripheral qualifier
// ----------------------------------------------------------------------------
`define QUAL_CONNECTED   3'h0
`define QUAL_NOT_CONN    3'h1
`define QUAL_NOT_SUPP    3'h3

`define ID_W             3
`define INFO_W           32

`endif

// >>> logic/scsi_status_pkg.sv
// types shared by the target status and exception logic
package scsi_status_pkg;

	typedef enum logic [2:0] {
		CMD_INQUIRY,
		CMD_REQ_SENSE,
		CMD_SEARCH,
		CMD_PREFETCH,
		CMD_OTHER
	} cmd_kind_e;

	typedef struct packed {
		logic [2:0] initiator;
		logic [2:0] lun;
		cmd_kind_e  kind;
		logic       param_bad;
		logic       param_roundable;
	} cmd_s;

	typedef struct packed {
		logic        err;
		logic [3:0]  sense_key;
		logic [7:0]  asc;
		logic        search_met;
		logic [31:0] match_lba;
		logic        prefetch_fit;
	} exec_s;

	typedef struct packed {
		logic [3:0]  key;
		logic [7:0]  asc;
		logic [31:0] info;
	} sense_s;

endpackage

// >>> logic/sense_slot.sv
// one held sense record for one initiator
`timescale 1ns/1ps

module sense_slot (
	input  wire logic                    clk_i,
	input  wire logic                    reset_n_i,
	input  wire logic                    load_i,
	input  scsi_status_pkg::sense_s      data_i,
	input  wire logic                    clear_i,
	output logic                         valid_o,
	output scsi_status_pkg::sense_s      data_o
);

	logic                    valid_q;
	logic                    valid_d;
	scsi_status_pkg::sense_s data_q;
	scsi_status_pkg::sense_s data_d;

	// a load in the same cycle as a clear wins, so fresh sense is never lost
	always_comb begin
		valid_d = valid_q;
		data_d  = data_q;
		if (load_i) begin
			valid_d = 1'b1;
			data_d  = data_i;
		end else if (clear_i) begin
			valid_d = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			valid_q <= 1'b0;
			data_q  <= '0;
		end else begin
			valid_q <= valid_d;
			data_q  <= data_d;
		end
	end

	assign valid_o = valid_q;
	assign data_o  = data_q;

endmodule

// >>> logic/scsi_status_unit.sv
// command completion: status byte choice, sense keeping, invalid lun handling
`timescale 1ns/1ps
`include "scsi_status_defines.svh"

module scsi_status_unit #(
	parameter int NUM_INIT = 8,
	parameter int NUM_LUN  = 8
) (
	input  wire logic                 clk_i,
	input  wire logic                 reset_n_i,
	input  wire logic                 cmd_valid_i,
	output logic                      cmd_ready_o,
	input  scsi_status_pkg::cmd_s     cmd_i,
	input  wire logic [NUM_LUN-1:0]   lun_supported_i,
	input  wire logic [NUM_LUN-1:0]   lun_attached_i,
	input  wire logic [NUM_LUN-1:0]   lun_operational_i,
	input  wire logic [NUM_LUN-1:0]   lun_known_i,
	input  wire logic                 target_busy_i,
	input  wire logic                 resv_conflict_i,
	output logic                      exec_req_o,
	output logic                      medium_write_ok_o,
	input  wire logic                 exec_done_i,
	input  scsi_status_pkg::exec_s    exec_result_i,
	output logic                      status_valid_o,
	output logic [7:0]                status_o,
	input  wire logic                 status_ack_i,
	output scsi_status_pkg::sense_s   sense_o,
	output logic [2:0]                inq_qualifier_o,
	output logic                      param_rounded_o
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_STATUS
	} state_e;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	state_e                  state_q;
	state_e                  state_d;
	scsi_status_pkg::cmd_s   cmd_q;
	scsi_status_pkg::cmd_s   cmd_d;
	logic [7:0]              status_q;
	logic [7:0]              status_d;
	scsi_status_pkg::sense_s sense_q;
	scsi_status_pkg::sense_s sense_d;
	logic [2:0]              qual_q;
	logic [2:0]              qual_d;
	logic                    round_q;
	logic                    round_d;

	logic [NUM_INIT-1:0]     slot_load;
	logic [NUM_INIT-1:0]     slot_clear;
	logic [NUM_INIT-1:0]     slot_valid;
	scsi_status_pkg::sense_s slot_wdata;
	scsi_status_pkg::sense_s slot_rdata [NUM_INIT];

	logic                    accept;
	logic                    lun_ok;
	logic                    lun_vague;

	assign accept    = cmd_valid_i && (state_q == ST_IDLE);
	assign lun_ok    = lun_supported_i[cmd_i.lun] && lun_attached_i[cmd_i.lun];
	assign lun_vague = !lun_operational_i[cmd_i.lun] || !lun_known_i[cmd_i.lun];

	// ------------------------------------------------------------------------
	// per-initiator sense storage
	// ------------------------------------------------------------------------
	for (genvar g = 0; g < NUM_INIT; g++) begin : g_slot
		sense_slot u_slot (
			.clk_i     (clk_i),
			.reset_n_i (reset_n_i),
			.load_i    (slot_load[g]),
			.data_i    (slot_wdata),
			.clear_i   (slot_clear[g]),
			.valid_o   (slot_valid[g]),
			.data_o    (slot_rdata[g])
		);
	end

	// ------------------------------------------------------------------------
	// decision logic
	// ------------------------------------------------------------------------
	always_comb begin
		state_d    = state_q;
		cmd_d      = cmd_q;
		status_d   = status_q;
		sense_d    = sense_q;
		qual_d     = qual_q;
		round_d    = round_q;
		slot_load  = '0;
		slot_clear = '0;
		slot_wdata = '0;
		unique case (state_q)
			ST_IDLE: begin
				if (accept) begin
					cmd_d   = cmd_i;
					qual_d  = `QUAL_CONNECTED;
					round_d = 1'b0;
					state_d = ST_STATUS;
					status_d = `ST_GOOD;
					if (cmd_i.kind != scsi_status_pkg::CMD_REQ_SENSE) begin
						slot_clear[cmd_i.initiator] = 1'b1;
					end
					if (cmd_i.kind == scsi_status_pkg::CMD_INQUIRY) begin
						if (!lun_supported_i[cmd_i.lun]) begin
							qual_d = `QUAL_NOT_SUPP;
						end else if (!lun_attached_i[cmd_i.lun] || lun_vague) begin
							qual_d = `QUAL_NOT_CONN;
						end
					end else if (cmd_i.kind == scsi_status_pkg::CMD_REQ_SENSE) begin
						if (!lun_ok) begin
							sense_d = '{`SK_ILLEGAL_REQ, `ASC_INVALID_LUN, '0};
						end else if (slot_valid[cmd_i.initiator]) begin
							sense_d = slot_rdata[cmd_i.initiator];
						end else begin
							// not-ready lun of unknown state falls here too
							sense_d = '{`SK_NO_SENSE, `ASC_NONE, '0};
						end
					end else if (!lun_ok) begin
						status_d   = `ST_CHECK;
						slot_wdata = '{`SK_ILLEGAL_REQ, `ASC_INVALID_LUN, '0};
						slot_load[cmd_i.initiator] = 1'b1;
					end else if (resv_conflict_i) begin
						status_d = `ST_RESV_CONFLICT;
					end else if (target_busy_i) begin
						// conflict is checked first: busy only for an acceptable initiator
						status_d = `ST_BUSY;
					end else if (cmd_i.param_bad && !cmd_i.param_roundable) begin
						// decided before execution starts, so the medium stays untouched
						status_d   = `ST_CHECK;
						slot_wdata = '{`SK_ILLEGAL_REQ, `ASC_INVALID_FLD, '0};
						slot_load[cmd_i.initiator] = 1'b1;
					end else begin
						round_d = cmd_i.param_bad;
						state_d = ST_EXEC;
					end
				end
			end
			ST_EXEC: begin
				if (exec_done_i) begin
					state_d = ST_STATUS;
					if (exec_result_i.err) begin
						status_d   = `ST_CHECK;
						slot_wdata = '{exec_result_i.sense_key, exec_result_i.asc, '0};
						slot_load[cmd_q.initiator] = 1'b1;
					end else if (cmd_q.kind == scsi_status_pkg::CMD_SEARCH
							&& exec_result_i.search_met) begin
						status_d   = `ST_COND_MET;
						slot_wdata = '{`SK_EQUAL, `ASC_NONE, exec_result_i.match_lba};
						slot_load[cmd_q.initiator] = 1'b1;
					end else if (cmd_q.kind == scsi_status_pkg::CMD_PREFETCH
							&& exec_result_i.prefetch_fit) begin
						status_d = `ST_COND_MET;
					end else begin
						status_d = `ST_GOOD;
					end
				end
			end
			ST_STATUS: begin
				if (status_ack_i) begin
					state_d = ST_IDLE;
					if (cmd_q.kind == scsi_status_pkg::CMD_REQ_SENSE) begin
						slot_clear[cmd_q.initiator] = 1'b1;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q  <= ST_IDLE;
			cmd_q    <= '0;
			status_q <= `ST_GOOD;
			sense_q  <= '0;
			qual_q   <= `QUAL_CONNECTED;
			round_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			cmd_q    <= cmd_d;
			status_q <= status_d;
			sense_q  <= sense_d;
			qual_q   <= qual_d;
			round_q  <= round_d;
		end
	end

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign cmd_ready_o       = (state_q == ST_IDLE);
	assign exec_req_o        = (state_q == ST_EXEC);
	assign medium_write_ok_o = (state_q == ST_EXEC);
	// a single byte held until acknowledged, then dropped
	assign status_valid_o    = (state_q == ST_STATUS);
	assign status_o          = status_q;
	assign sense_o           = sense_q;
	assign inq_qualifier_o   = qual_q;
	assign param_rounded_o   = round_q;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	logic acc_other;
	assign acc_other = accept && lun_ok && cmd_i.kind != scsi_status_pkg::CMD_INQUIRY
		&& cmd_i.kind != scsi_status_pkg::CMD_REQ_SENSE;

	property p_one_status;
		// a byte two cycles on is only legal for a command taken right after the ack
		status_valid_o && status_ack_i
			|=> !status_valid_o ##1 (!status_valid_o || $past(accept));
	endproperty
	a_one_status: assert property (p_one_status) else $error("status repeated");

	property p_status_hold;
		status_valid_o && !status_ack_i |=> status_valid_o && $stable(status_o);
	endproperty
	a_status_hold: assert property (p_status_hold) else $error("status moved");

	property p_no_good_on_err;
		exec_req_o && exec_done_i && exec_result_i.err |=> status_o != `ST_GOOD;
	endproperty
	a_no_good_on_err: assert property (p_no_good_on_err) else $error("good on error");

	property p_err_check;
		exec_req_o && exec_done_i && exec_result_i.err |=> status_valid_o && status_o == `ST_CHECK;
	endproperty
	a_err_check: assert property (p_err_check) else $error("no check on error");

	property p_search_met;
		exec_req_o && exec_done_i && !exec_result_i.err && exec_result_i.search_met
			&& cmd_q.kind == scsi_status_pkg::CMD_SEARCH |=> status_o == `ST_COND_MET;
	endproperty
	a_search_met: assert property (p_search_met) else $error("search not met");

	property p_busy;
		acc_other && !resv_conflict_i && target_busy_i |=> status_valid_o && status_o == `ST_BUSY;
	endproperty
	a_busy: assert property (p_busy) else $error("busy missing");

	property p_conflict;
		acc_other && resv_conflict_i |=> status_o == `ST_RESV_CONFLICT;
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict missing");

	property p_no_intermediate;
		status_valid_o |-> status_o != `ST_INTERMEDIATE;
	endproperty
	a_no_intermediate: assert property (p_no_intermediate) else $error("intermediate");

	property p_no_queue_full;
		status_valid_o |-> status_o != `ST_QUEUE_FULL;
	endproperty
	a_no_queue_full: assert property (p_no_queue_full) else $error("queue full");

	property p_bad_lun_check;
		accept && !lun_ok && cmd_i.kind == scsi_status_pkg::CMD_OTHER
			|=> status_o == `ST_CHECK ##0 !exec_req_o;
	endproperty
	a_bad_lun_check: assert property (p_bad_lun_check) else $error("bad lun ran");

	property p_reject_no_medium;
		acc_other && !resv_conflict_i && !target_busy_i && cmd_i.param_bad
			&& !cmd_i.param_roundable |=> !medium_write_ok_o [*2];
	endproperty
	a_reject_no_medium: assert property (p_reject_no_medium) else $error("medium touched");

	property p_rsvd_zero;
		status_valid_o |-> (status_o & `ST_RSVD_MASK) == 8'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

	c_check: cover property (status_valid_o && status_o == `ST_CHECK);
	c_cond_met: cover property (status_valid_o && status_o == `ST_COND_MET);
	c_busy: cover property (status_valid_o && status_o == `ST_BUSY);
	c_inq_bad: cover property (status_valid_o && inq_qualifier_o != `QUAL_CONNECTED);

endmodule

// >>> test/scsi_initiator_model.sv
// initiator-side model: offers commands, takes status bytes, follows up
`timescale 1ns/1ps
`include "scsi_status_defines.svh"

module scsi_initiator_model (
	input  wire logic              clk_i,
	input  wire logic              cmd_ready_i,
	input  wire logic              status_valid_i,
	input  wire logic [7:0]        status_i,
	output logic                   cmd_valid_o,
	output scsi_status_pkg::cmd_s  cmd_o,
	output logic                   status_ack_o
);
	initial begin
		cmd_valid_o = 1'b0;
		cmd_o = '0;
		status_ack_o = 1'b0;
	end

	// ------------------------------------------------------------------
	// one command, one status byte; ack held back for gap cycles
	// ------------------------------------------------------------------
	task automatic xfer(input scsi_status_pkg::cmd_s c, input int gap, output logic [7:0] st);
		int n;
		n = 0;
		st = 8'hXX;
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_o <= c;
		do begin
			@(negedge clk_i);
			n++;
		end while (cmd_ready_i !== 1'b1 && n < 200);
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (status_valid_i !== 1'b1 && n < 200);
		if (status_valid_i === 1'b1) begin
			st = status_i;
		end
		repeat (gap) @(negedge clk_i);
		@(posedge clk_i);
		status_ack_o <= 1'b1;
		@(posedge clk_i);
		status_ack_o <= 1'b0;
	endtask

	task automatic issue(input scsi_status_pkg::cmd_s c, input int gap, input bit retry,
		input bit sense, output logic [7:0] st);
		logic [7:0] st2;
		xfer(c, gap, st);
		if (retry && st === `ST_BUSY) begin
			repeat (4) @(posedge clk_i);
			xfer(c, gap, st);
		end
		// the sense read is issued at once, before any other command clears it
		if (sense && (st === `ST_CHECK || st === `ST_COND_MET)) begin
			c.kind = scsi_status_pkg::CMD_REQ_SENSE;
			xfer(c, 0, st2);
		end
	endtask
endmodule

// >>> test/scsi_target_status_and_exceptions_tb.sv
// self-checking bench for the command completion unit
`timescale 1ns/1ps
`include "scsi_status_defines.svh"

module scsi_target_status_and_exceptions_tb;
	typedef struct {
		scsi_status_pkg::cmd_s  c;
		logic                   bz;
		logic                   rv;
		scsi_status_pkg::exec_s r;
		logic [7:0]             st;
		logic [11:0]            sa;
		logic [2:0]             q;
		logic                   ex;
	} row_s;
	localparam logic [31:0] LBA = 32'h00AB_CDEF;
	localparam scsi_status_pkg::cmd_kind_e K_OTH = scsi_status_pkg::CMD_OTHER;
	localparam scsi_status_pkg::cmd_kind_e K_INQ = scsi_status_pkg::CMD_INQUIRY;
	localparam scsi_status_pkg::cmd_kind_e K_RS = scsi_status_pkg::CMD_REQ_SENSE;
	localparam scsi_status_pkg::cmd_kind_e K_SR = scsi_status_pkg::CMD_SEARCH;
	localparam scsi_status_pkg::cmd_kind_e K_PF = scsi_status_pkg::CMD_PREFETCH;

	logic                    clk_i, reset_n_i, cmd_valid_i, cmd_ready_o, status_ack_i;
	logic                    target_busy_i, resv_conflict_i, exec_req_o, medium_write_ok_o;
	logic                    exec_done_i, status_valid_o, param_rounded_o, stray;
	logic [7:0]              lun_sup, lun_att, lun_op, lun_kn, status_o, st;
	logic [2:0]              inq_qualifier_o;
	scsi_status_pkg::cmd_s   cmd_i;
	scsi_status_pkg::exec_s  exec_result_i, cur_res;
	scsi_status_pkg::sense_s sense_o;
	int                      err_total, cmp_count, exec_cnt, exec_dly, e0;
	row_s                    rows[22];

	scsi_status_unit i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i), .lun_supported_i(lun_sup),
		.lun_attached_i(lun_att), .lun_operational_i(lun_op), .lun_known_i(lun_kn),
		.target_busy_i(target_busy_i), .resv_conflict_i(resv_conflict_i),
		.exec_req_o(exec_req_o), .medium_write_ok_o(medium_write_ok_o),
		.exec_done_i(exec_done_i), .exec_result_i(exec_result_i),
		.status_valid_o(status_valid_o), .status_o(status_o), .status_ack_i(status_ack_i),
		.sense_o(sense_o), .inq_qualifier_o(inq_qualifier_o),
		.param_rounded_o(param_rounded_o));

	scsi_initiator_model i_init (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o),
		.status_valid_i(status_valid_o), .status_i(status_o), .cmd_valid_o(cmd_valid_i),
		.cmd_o(cmd_i), .status_ack_o(status_ack_i));

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// info is only defined for a search hit, so it is compared only there
	task automatic chk_sense(input logic [11:0] e, input scsi_status_pkg::sense_s g);
		cmp_count++;
		if ({g.key, g.asc} !== e || (e[11:8] == `SK_EQUAL && g.info !== LBA)) begin
			err_total++;
			$display("MISMATCH sense expected %h seen %h", e, g);
		end
	endtask

	task automatic test_done();
		if (err_total == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// f = {param bad, roundable, busy, conflict}; es = {key, asc, 00, hit, fits}
	function automatic row_s mk(input logic [2:0] ini, input logic [2:0] lun,
		input scsi_status_pkg::cmd_kind_e k, input logic [3:0] f, input logic [15:0] es,
		input logic [7:0] s, input logic [11:0] sa, input logic [2:0] q, input logic ex);
		row_s w;
		w.c = '{ini, lun, k, f[3], f[2]};
		w.bz = f[1];
		w.rv = f[0];
		w.r = '{es[15:12] != 4'h0, es[15:12], es[11:4], es[1], LBA, es[0]};
		w.st = s;
		w.sa = sa;
		w.q = q;
		w.ex = ex;
		return w;
	endfunction

	task automatic run(input row_s w, input int gap, input bit sn);
		e0 = exec_cnt;
		cur_res = w.r;
		@(posedge clk_i);
		target_busy_i <= w.bz;
		resv_conflict_i <= w.rv;
		i_init.issue(w.c, gap, 1'b0, sn, st);
		chk("status", w.st, st);
		chk("exec", w.ex, exec_cnt - e0);
		if (w.c.kind == K_RS || (sn && (w.st == `ST_CHECK || w.st == `ST_COND_MET))) begin
			chk_sense(w.sa, sense_o);
		end
		if (w.c.kind == K_INQ) begin
			chk("qualifier", w.q, inq_qualifier_o);
		end
		if (w.c.kind == K_OTH) begin
			chk("rounded", w.c.param_bad & w.c.param_roundable, param_rounded_o);
		end
	endtask

	task automatic check_idle();
		@(negedge clk_i);
		chk("idle", 8'h80, {cmd_ready_o, exec_req_o, medium_write_ok_o, status_valid_o,
			inq_qualifier_o, param_rounded_o});
		chk("rst status", 8'h00, status_o);
		chk("rst sense", 32'h0, {sense_o.key, sense_o.asc});
	endtask

	// ------------------------------------------------------------------
	// clock, execution side, watchdog
	// ------------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	initial begin
		exec_done_i = 1'b0;
		exec_result_i = '0;
		forever begin
			@(negedge clk_i);
			// a stray request gives a completion pulse while the unit is idle
			if (exec_req_o === 1'b1 || stray === 1'b1) begin
				if (exec_req_o === 1'b1) begin
					exec_cnt++;
				end
				repeat (exec_dly) @(negedge clk_i);
				@(posedge clk_i);
				exec_done_i <= 1'b1;
				exec_result_i <= cur_res;
				@(posedge clk_i);
				exec_done_i <= 1'b0;
			end
		end
	end

	always @(negedge clk_i) begin
		if (reset_n_i === 1'b1) begin
			chk("medium", exec_req_o, medium_write_ok_o);
		end
	end

	initial begin
		#1000000;
		err_total++;
		test_done();
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		reset_n_i = 1'b0;
		stray = 1'b0;
		{target_busy_i, resv_conflict_i} = 2'b00;
		{lun_sup, lun_att, lun_op, lun_kn} = {8'h0F, 8'h07, 8'h03, 8'h01};
		rows = '{
			mk(3'h0, 3'h0, K_OTH, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b1),
			mk(3'h0, 3'h0, K_INQ, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b0),
			mk(3'h0, 3'h4, K_INQ, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h3, 1'b0),
			mk(3'h0, 3'h3, K_INQ, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h1, 1'b0),
			mk(3'h0, 3'h2, K_INQ, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h1, 1'b0),
			mk(3'h0, 3'h1, K_INQ, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h1, 1'b0),
			mk(3'h0, 3'h4, K_OTH, 4'h0, 16'h0000, 8'h02, 12'h525, 3'h0, 1'b0),
			mk(3'h0, 3'h3, K_OTH, 4'h0, 16'h0000, 8'h02, 12'h525, 3'h0, 1'b0),
			mk(3'h0, 3'h0, K_OTH, 4'h1, 16'h0000, 8'h18, 12'h000, 3'h0, 1'b0),
			mk(3'h0, 3'h0, K_OTH, 4'h2, 16'h0000, 8'h08, 12'h000, 3'h0, 1'b0),
			mk(3'h0, 3'h0, K_OTH, 4'h3, 16'h0000, 8'h18, 12'h000, 3'h0, 1'b0),
			mk(3'h0, 3'h0, K_OTH, 4'h8, 16'h0000, 8'h02, 12'h524, 3'h0, 1'b0),
			mk(3'h0, 3'h0, K_OTH, 4'hC, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b1),
			mk(3'h0, 3'h0, K_OTH, 4'h0, 16'h3110, 8'h02, 12'h311, 3'h0, 1'b1),
			mk(3'h0, 3'h0, K_SR, 4'h0, 16'h0002, 8'h04, 12'hC00, 3'h0, 1'b1),
			mk(3'h0, 3'h0, K_SR, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b1),
			mk(3'h0, 3'h0, K_PF, 4'h0, 16'h0001, 8'h04, 12'h000, 3'h0, 1'b1),
			mk(3'h0, 3'h0, K_PF, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b1),
			mk(3'h0, 3'h1, K_OTH, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b1),
			mk(3'h0, 3'h1, K_RS, 4'h0, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b0),
			mk(3'h0, 3'h4, K_RS, 4'h0, 16'h0000, 8'h00, 12'h525, 3'h0, 1'b0),
			mk(3'h0, 3'h0, K_INQ, 4'h3, 16'h0000, 8'h00, 12'h000, 3'h0, 1'b0)};
		repeat (16) @(posedge clk_i);
		check_idle();
		@(posedge clk_i);
		reset_n_i <= 1'b1;
		foreach (rows[i]) begin
			exec_dly = i % 4;
			run(rows[i], i % 3, 1'b1);
		end
		// sense outlives other initiators' commands, goes once read or on its own initiator's next command
		run(mk(3'h1, 3'h0, K_OTH, 4'h8, 16'h0, 8'h02, 12'h524, 3'h0, 1'b0), 5, 1'b0);
		run(mk(3'h2, 3'h0, K_OTH, 4'h0, 16'h0, 8'h00, 12'h000, 3'h0, 1'b1), 0, 1'b0);
		run(mk(3'h1, 3'h0, K_RS, 4'h0, 16'h0, 8'h00, 12'h524, 3'h0, 1'b0), 0, 1'b0);
		run(mk(3'h1, 3'h0, K_RS, 4'h0, 16'h0, 8'h00, 12'h000, 3'h0, 1'b0), 0, 1'b0);
		run(mk(3'h1, 3'h0, K_OTH, 4'h8, 16'h0, 8'h02, 12'h524, 3'h0, 1'b0), 0, 1'b0);
		run(mk(3'h1, 3'h0, K_OTH, 4'h0, 16'h0, 8'h00, 12'h000, 3'h0, 1'b1), 0, 1'b0);
		run(mk(3'h1, 3'h0, K_RS, 4'h0, 16'h0, 8'h00, 12'h000, 3'h0, 1'b0), 0, 1'b0);
		// busy, then the same command again once the target frees up
		e0 = exec_cnt;
		cur_res = '0;
		target_busy_i <= 1'b1;
		fork
			i_init.issue(rows[0].c, 0, 1'b1, 1'b0, st);
			begin
				wait (status_ack_i === 1'b1);
				@(posedge clk_i);
				target_busy_i <= 1'b0;
			end
		join
		chk("retry status", `ST_GOOD, st);
		chk("retry exec", 1, exec_cnt - e0);
		// a stray completion while idle must not produce a status byte
		cur_res = rows[13].r;
		stray = 1'b1;
		wait (exec_done_i === 1'b1);
		stray = 1'b0;
		repeat (2) @(negedge clk_i);
		chk("stray", 1'b0, status_valid_o);
		run(rows[0], 0, 1'b0);
		// reset in mid-execution
		exec_dly = 40;
		fork
			i_init.issue(rows[0].c, 0, 1'b0, 1'b0, st);
			begin
				wait (exec_req_o === 1'b1);
				@(posedge clk_i);
				reset_n_i <= 1'b0;
				check_idle();
				@(posedge clk_i);
				reset_n_i <= 1'b1;
			end
		join
		exec_dly = 0;
		run(rows[13], 0, 1'b1);
		test_done();
	end
endmodule
